// ==== rtl/tocpa_pkg.sv ====
/*
 * Types of the output compare and pulse accumulator block.
 * Assumes tocpa_regs.svh for all numeric constants.
 */
package tocpa_pkg;

	typedef struct packed {
		logic        hsel;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] haddr;
		logic [31:0] hwdata;
		logic        hready;
	} tocpa_ahb_req_t;

	typedef struct packed {
		logic        hreadyout;
		logic        hresp;
		logic [31:0] hrdata;
	} tocpa_ahb_rsp_t;

	typedef struct packed {
		logic [7:0] pa_out;
		logic [7:0] pa_oe;
	} tocpa_pins_t;

	typedef struct packed {
		logic            pend;
		logic            wr;
		logic            hi_zero;
		logic [5:0]      idx;
		tocpa_ahb_rsp_t  rsp;
		logic [4:0][15:0] cmp;
		logic [4:0]      mp_mask;
		logic [4:0]      mp_data;
		logic [7:0]      pin_ctrl;
		logic [7:0]      ien_one;
		logic [4:0]      flags_one;
		logic [1:0]      ien_two;
		logic [1:0]      flags_two;
		logic [7:0]      acc_ctrl;
		logic [7:0]      acc_count;
		logic [5:0]      div;
		logic            acc_in_prev;
		logic [4:0]      force_pend;
		tocpa_pins_t     pins;
		logic [7:0]      sync1;
		logic [7:0]      sync2;
		logic            irq;
	} tocpa_state_t;

endpackage

// ==== rtl/tocpa_regs.svh ====
/*
 * Register indices, field positions, reset values and counts of the
 * output compare and pulse accumulator block.
 * Assumes a 32-bit bus with one word per register, byte address = index * 4.
 */
`ifndef TOCPA_REGS_SVH
`define TOCPA_REGS_SVH

// Register indices
`define TOCPA_IDX_PORT_DATA   6'h00
`define TOCPA_IDX_PORT_DIR    6'h01
`define TOCPA_IDX_FORCE       6'h0B
`define TOCPA_IDX_MP_MASK     6'h0C
`define TOCPA_IDX_MP_DATA     6'h0D
`define TOCPA_IDX_CMP1        6'h10
`define TOCPA_IDX_CMP2        6'h11
`define TOCPA_IDX_CMP3        6'h12
`define TOCPA_IDX_CMP4        6'h13
`define TOCPA_IDX_SHARED      6'h14
`define TOCPA_IDX_PIN_CTRL    6'h20
`define TOCPA_IDX_IEN_ONE     6'h22
`define TOCPA_IDX_FLAGS_ONE   6'h23
`define TOCPA_IDX_IEN_TWO     6'h24
`define TOCPA_IDX_FLAGS_TWO   6'h25
`define TOCPA_IDX_ACC_CTRL    6'h26
`define TOCPA_IDX_ACC_COUNT   6'h27

// Accumulator control fields
`define TOCPA_ACC_ON_BIT      6
`define TOCPA_ACC_MODE_BIT    5
`define TOCPA_ACC_EDGE_BIT    4
`define TOCPA_CAP_SEL_BIT     2
`define TOCPA_ACC_CTRL_WMASK  8'h77

// Second flag and enable register fields
`define TOCPA_OVF_BIT         5
`define TOCPA_EDGE_FLAG_BIT   4

// First flag register: channel five flag position
`define TOCPA_SHARED_BIT      3

// Reset values
`define TOCPA_CMP_RESET       16'hFFFF
`define TOCPA_BYTE_RESET      8'h00

// Gated accumulation divider
`define TOCPA_GATE_DIV        64
`define TOCPA_DIV_LAST        6'(`TOCPA_GATE_DIV - 1)

`endif

// ==== rtl/tocpa_top.sv ====
/*
 * Output compare channels one to five and the 8-bit pulse accumulator,
 * with port A drive and an AHB-Lite register slave.
 * Assumes the timer core supplies the free-running count and a one-cycle
 * pulse on each count transition, both on hclk; port A pins are asynchronous.
 */
`timescale 1ns/1ps
`include "tocpa_regs.svh"

module tocpa_top
	import tocpa_pkg::*;
(
	input  wire logic           hclk,
	input  wire logic           hresetn,
	input  wire logic           ce,
	input  wire tocpa_ahb_req_t ahb_req,
	output tocpa_ahb_rsp_t      ahb_rsp,
	input  wire logic [15:0]    timer_count,
	input  wire logic           timer_tick,
	input  wire logic [7:0]     pa_in,
	output tocpa_pins_t         pa_pins,
	output logic                irq
);

	tocpa_state_t state_reg;
	tocpa_state_t state_next;
	logic [4:0]   match;
	logic [4:0]   fire;
	logic         ch5_en;
	logic         acc_in;
	logic         sel_edge;
	logic         acc_inc;
	logic         wr_now;
	logic [31:0]  rdata;

	assign ahb_rsp = state_reg.rsp;
	assign pa_pins = state_reg.pins;
	assign irq     = state_reg.irq;

	assign ch5_en = ~state_reg.acc_ctrl[`TOCPA_CAP_SEL_BIT];
	assign wr_now = state_reg.pend & state_reg.wr & state_reg.hi_zero;

	// Per channel match against the supplied count
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_match
			if (gi == 4) begin : g_shared
				assign match[gi] = timer_tick & ch5_en & (timer_count == state_reg.cmp[gi]);
			end else begin : g_dedicated
				assign match[gi] = timer_tick & (timer_count == state_reg.cmp[gi]);
			end
			assign fire[gi] = match[gi] | (timer_tick & state_reg.force_pend[gi]);
		end
	endgenerate

	// Accumulator input follows the driven level when bit 7 is an output
	assign acc_in   = state_reg.pins.pa_oe[7] ? state_reg.pins.pa_out[7] :
		state_reg.sync2[7];
	assign sel_edge = state_reg.acc_ctrl[`TOCPA_ACC_EDGE_BIT] ?
		(acc_in & ~state_reg.acc_in_prev) : (~acc_in & state_reg.acc_in_prev);
	always_comb begin
		acc_inc = 1'b0;
		if (state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT]) begin
			if (state_reg.acc_ctrl[`TOCPA_ACC_MODE_BIT]) begin
				acc_inc = (state_reg.div == `TOCPA_DIV_LAST) &
					(acc_in != state_reg.acc_ctrl[`TOCPA_ACC_EDGE_BIT]);
			end else begin
				acc_inc = sel_edge;
			end
		end
	end

	// Register read view
	always_comb begin
		rdata = 32'h0000_0000;
		unique case (state_reg.idx)
			`TOCPA_IDX_PORT_DATA: rdata[7:0] = state_reg.pins.pa_out;
			`TOCPA_IDX_PORT_DIR:  rdata[7:0] = state_reg.pins.pa_oe;
			`TOCPA_IDX_MP_MASK:   rdata[7:3] = state_reg.mp_mask;
			`TOCPA_IDX_MP_DATA:   rdata[7:3] = state_reg.mp_data;
			`TOCPA_IDX_CMP1:      rdata[15:0] = state_reg.cmp[0];
			`TOCPA_IDX_CMP2:      rdata[15:0] = state_reg.cmp[1];
			`TOCPA_IDX_CMP3:      rdata[15:0] = state_reg.cmp[2];
			`TOCPA_IDX_CMP4:      rdata[15:0] = state_reg.cmp[3];
			`TOCPA_IDX_SHARED:    rdata[15:0] = state_reg.cmp[4];
			`TOCPA_IDX_PIN_CTRL:  rdata[7:0] = state_reg.pin_ctrl;
			`TOCPA_IDX_IEN_ONE:   rdata[7:0] = state_reg.ien_one;
			`TOCPA_IDX_FLAGS_ONE: rdata[7:3] = state_reg.flags_one;
			`TOCPA_IDX_IEN_TWO:   rdata[5:4] = state_reg.ien_two;
			`TOCPA_IDX_FLAGS_TWO: rdata[5:4] = state_reg.flags_two;
			`TOCPA_IDX_ACC_CTRL:  rdata[7:0] = state_reg.acc_ctrl;
			`TOCPA_IDX_ACC_COUNT: rdata[7:0] = state_reg.acc_count;
			default:              rdata = 32'h0000_0000;
		endcase
		if (!state_reg.hi_zero) begin
			rdata = 32'h0000_0000;
		end
	end

	always_comb begin
		logic [7:0] wd;
		logic [4:0] clr_one;
		logic [1:0] clr_two;
		logic [4:0] set_one;
		logic [1:0] set_two;
		logic [7:0] port;
		wd         = ahb_req.hwdata[7:0];
		clr_one    = 5'h00;
		clr_two    = 2'h0;
		set_one    = 5'h00;
		set_two    = 2'h0;
		port       = state_reg.pins.pa_out;
		state_next = state_reg;
		state_next.rsp.hresp = 1'b0;
		state_next.sync1     = pa_in;
		state_next.sync2     = state_reg.sync1;
		state_next.acc_in_prev = acc_in;

		// Bus: address phase, then one wait cycle, then data phase end
		if (state_reg.pend) begin
			state_next.pend          = 1'b0;
			state_next.rsp.hreadyout = 1'b1;
			if (!state_reg.wr) begin
				state_next.rsp.hrdata = rdata;
			end
		end else if (ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready) begin
			state_next.pend          = 1'b1;
			state_next.wr            = ahb_req.hwrite;
			state_next.idx           = ahb_req.haddr[7:2];
			state_next.hi_zero       = (ahb_req.haddr[31:8] == 24'h00_0000);
			state_next.rsp.hreadyout = 1'b0;
		end

		// Force strobes wait for the next count transition
		if (timer_tick) begin
			state_next.force_pend = 5'h00;
		end

		// Register writes
		if (wr_now) begin
			unique case (state_reg.idx)
				`TOCPA_IDX_PORT_DATA: port = wd;
				`TOCPA_IDX_PORT_DIR:  state_next.pins.pa_oe = wd;
				`TOCPA_IDX_FORCE:     state_next.force_pend = state_next.force_pend | wd[7:3];
				`TOCPA_IDX_MP_MASK:   state_next.mp_mask = wd[7:3];
				`TOCPA_IDX_MP_DATA:   state_next.mp_data = wd[7:3];
				`TOCPA_IDX_CMP1:      state_next.cmp[0] = ahb_req.hwdata[15:0];
				`TOCPA_IDX_CMP2:      state_next.cmp[1] = ahb_req.hwdata[15:0];
				`TOCPA_IDX_CMP3:      state_next.cmp[2] = ahb_req.hwdata[15:0];
				`TOCPA_IDX_CMP4:      state_next.cmp[3] = ahb_req.hwdata[15:0];
				`TOCPA_IDX_SHARED:    state_next.cmp[4] = ahb_req.hwdata[15:0];
				`TOCPA_IDX_PIN_CTRL:  state_next.pin_ctrl = wd;
				`TOCPA_IDX_IEN_ONE:   state_next.ien_one = wd;
				`TOCPA_IDX_FLAGS_ONE: clr_one = wd[7:3];
				`TOCPA_IDX_IEN_TWO:   state_next.ien_two = wd[5:4];
				`TOCPA_IDX_FLAGS_TWO: clr_two = wd[5:4];
				`TOCPA_IDX_ACC_CTRL:  state_next.acc_ctrl = wd & `TOCPA_ACC_CTRL_WMASK;
				`TOCPA_IDX_ACC_COUNT: state_next.acc_count = wd;
				default:              state_next.acc_count = state_next.acc_count;
			endcase
		end

		// Pin actions of channels two to five, channel one applied last
		for (int k = 1; k < 5; k++) begin
			if (fire[k]) begin
				unique case (state_reg.pin_ctrl[8 - 2 * k +: 2])
					2'b01:   port[7 - k] = ~state_reg.pins.pa_out[7 - k];
					2'b10:   port[7 - k] = 1'b0;
					2'b11:   port[7 - k] = 1'b1;
					default: port[7 - k] = port[7 - k];
				endcase
			end
		end
		if (fire[0]) begin
			port[7:3] = (port[7:3] & ~state_reg.mp_mask) | (state_reg.mp_data & state_reg.mp_mask);
		end
		state_next.pins.pa_out = port;

		// Compare flags from real matches only
		for (int k = 0; k < 5; k++) begin
			set_one[4 - k] = match[k];
		end

		// Pulse accumulator
		if (state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT] && state_reg.acc_ctrl[`TOCPA_ACC_MODE_BIT]) begin
			state_next.div = state_reg.div + 6'd1;
		end else begin
			state_next.div = 6'd0;
		end
		if (acc_inc && !(wr_now && state_reg.idx == `TOCPA_IDX_ACC_COUNT)) begin
			state_next.acc_count = state_reg.acc_count + 8'd1;
			set_two[1] = (state_reg.acc_count == 8'hFF);
		end
		set_two[0] = state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT] & sel_edge;

		// Set wins over a simultaneous clear
		state_next.flags_one = (state_reg.flags_one & ~clr_one) | set_one;
		state_next.flags_two = (state_reg.flags_two & ~clr_two) | set_two;

		// Interrupt request
		state_next.irq = (|(state_reg.ien_one[7:4] & state_reg.flags_one[4:1])) |
			(state_reg.ien_one[3] & ch5_en & state_reg.flags_one[0]) |
			(|(state_reg.ien_two & state_reg.flags_two));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg               <= '0;
			state_reg.rsp.hreadyout <= 1'b1;
			state_reg.cmp           <= {5{`TOCPA_CMP_RESET}};
			state_reg.acc_ctrl      <= `TOCPA_BYTE_RESET;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	// Checks
	chk_match_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && match[1] |=> state_reg.flags_one[3])
		else $error("match did not set its flag");

	chk_zero_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && wr_now && state_reg.idx == `TOCPA_IDX_FLAGS_ONE && !ahb_req.hwdata[6]
		&& state_reg.flags_one[3] |=> state_reg.flags_one[3])
		else $error("zero write cleared a flag");

	chk_shared_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !ch5_en && !state_reg.flags_one[0] |=> !state_reg.flags_one[0])
		else $error("shared flag set while capture selected");

	chk_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.ien_one[6] && state_reg.flags_one[3] |=> irq)
		else $error("enabled flag gave no interrupt");

	chk_irq_shared: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !ch5_en && state_reg.ien_one[7:4] == 4'h0 && state_reg.ien_two == 2'h0
		|=> !irq)
		else $error("shared interrupt while capture selected");

	chk_pin_high: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && fire[1] && !fire[0] && state_reg.pin_ctrl[7:6] == 2'b11 |=> pa_pins.pa_out[6])
		else $error("set action did not drive high");

	chk_pin_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && fire[2] && !fire[0] && state_reg.pin_ctrl[5:4] == 2'b01
		|=> pa_pins.pa_out[5] != $past(pa_pins.pa_out[5]))
		else $error("toggle action did not toggle");

	chk_force_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !match[2] && !state_reg.flags_one[2] |=> !state_reg.flags_one[2])
		else $error("flag set without a match");

	chk_force_delay: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !timer_tick && state_reg.force_pend[2] |=> state_reg.force_pend[2])
		else $error("force lost before count transition");

	chk_mask_copy: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && fire[0] && state_reg.mp_mask[0] |=> pa_pins.pa_out[3] == $past(state_reg.mp_data[0]))
		else $error("channel one data not copied");

	chk_acc_off: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT] && !wr_now |=> $stable(state_reg.acc_count))
		else $error("accumulator counted while disabled");

	chk_acc_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && acc_inc && !wr_now && state_reg.acc_count == 8'hFF
		|=> state_reg.acc_count == 8'h00 && state_reg.flags_two[1])
		else $error("rollover did not set overflow");

	chk_gate_rate: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.acc_ctrl[`TOCPA_ACC_MODE_BIT] && state_reg.div != `TOCPA_DIV_LAST
		&& !wr_now |=> $stable(state_reg.acc_count))
		else $error("gated count off the divider");

	chk_bus_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !state_reg.pend && ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready
		|=> !ahb_rsp.hreadyout)
		else $error("bus took no wait state");

	chk_bus_done: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.pend |=> ahb_rsp.hreadyout)
		else $error("bus wait state too long");

	chk_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
		ce |=> !ahb_rsp.hresp)
		else $error("bus response not okay");

	chk_cmp_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !(wr_now && state_reg.idx == `TOCPA_IDX_CMP1) |=> $stable(state_reg.cmp[0]))
		else $error("compare value changed without a write");

	chk_shared_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !(wr_now && state_reg.idx == `TOCPA_IDX_SHARED) |=> $stable(state_reg.cmp[4]))
		else $error("shared value changed without a write");

	chk_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && wr_now && state_reg.idx == `TOCPA_IDX_FLAGS_ONE && ahb_req.hwdata[6]
		&& !match[1] |=> !state_reg.flags_one[3])
		else $error("written one did not clear flag");

	chk_shared_set: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && match[4] |=> state_reg.flags_one[0])
		else $error("shared match did not set flag");

	chk_irq_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.ien_one == 8'h00 && state_reg.ien_two == 2'h0 |=> !irq)
		else $error("interrupt with all enables off");

	chk_pin_low: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && fire[3] && !fire[0] && state_reg.pin_ctrl[3:2] == 2'b10 |=> !pa_pins.pa_out[4])
		else $error("clear action did not drive low");

	chk_pin_none: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && fire[4] && !fire[0] && state_reg.pin_ctrl[1:0] == 2'b00 && !wr_now
		|=> $stable(pa_pins.pa_out[3]))
		else $error("disconnected channel moved its pin");

	chk_force_clear: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && timer_tick && !wr_now |=> state_reg.force_pend == 5'h00)
		else $error("force outlived its count transition");

	chk_mask_read: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.pend && !state_reg.wr && state_reg.idx == `TOCPA_IDX_MP_MASK
		|=> ahb_rsp.hrdata[2:0] == 3'b000)
		else $error("mask low bits not zero");

	chk_edge_count: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT] && !state_reg.acc_ctrl[`TOCPA_ACC_MODE_BIT]
		&& sel_edge && !wr_now |=> state_reg.acc_count == $past(state_reg.acc_count) + 8'd1)
		else $error("selected edge not counted");

	chk_event_idle: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT] && !state_reg.acc_ctrl[`TOCPA_ACC_MODE_BIT]
		&& !sel_edge && !wr_now |=> $stable(state_reg.acc_count))
		else $error("event mode counted without an edge");

	chk_gate_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.acc_ctrl[`TOCPA_ACC_MODE_BIT]
		&& acc_in == state_reg.acc_ctrl[`TOCPA_ACC_EDGE_BIT] && !wr_now
		|=> $stable(state_reg.acc_count))
		else $error("gated count at inhibiting level");

	chk_edge_flag: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && state_reg.acc_ctrl[`TOCPA_ACC_ON_BIT] && sel_edge |=> state_reg.flags_two[0])
		else $error("selected edge did not set flag");

endmodule

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for the output compare and pulse accumulator block.
 * Assumes the port model beside it; a register model is kept here.
 */
`timescale 1ns/1ps
`include "tocpa_regs.svh"

module tb
	import tocpa_pkg::*;
;
	logic           hclk;
	logic           hresetn;
	logic           hsel;
	logic [1:0]     htrans;
	logic           hwrite;
	logic [31:0]    haddr;
	logic [31:0]    hwdata;
	logic [15:0]    tcnt;
	logic           ttick;
	logic [7:0]     pa_in;
	logic           irq;
	tocpa_ahb_req_t req;
	tocpa_ahb_rsp_t rsp;
	tocpa_pins_t    pins;
	logic [31:0]    mdl [64];
	logic [15:0]    cv [5];
	logic [7:0]     po;
	logic [31:0]    v;
	int             n;
	logic           lvl;
	int             mismatches;
	int             comparisons;

	assign req = '{hsel, htrans, hwrite, 3'b010, haddr, hwdata, rsp.hreadyout};

	tocpa_top dut (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.ce          (1'b1),
		.ahb_req     (req),
		.ahb_rsp     (rsp),
		.timer_count (tcnt),
		.timer_tick  (ttick),
		.pa_in       (pa_in),
		.pa_pins     (pins),
		.irq         (irq)
	);

	tocpa_port_model pm (
		.hclk  (hclk),
		.pins  (pins),
		.pa_in (pa_in),
		.ext7  ()
	);

	always #50 hclk = ~hclk;

	function automatic logic [31:0] rmask(input logic [5:0] i);
		case (i)
			`TOCPA_IDX_PORT_DIR, `TOCPA_IDX_PIN_CTRL, `TOCPA_IDX_IEN_ONE,
			`TOCPA_IDX_ACC_COUNT: rmask = 32'h0000_00ff;
			`TOCPA_IDX_MP_MASK, `TOCPA_IDX_MP_DATA, `TOCPA_IDX_FLAGS_ONE: rmask = 32'h0000_00f8;
			`TOCPA_IDX_CMP1, `TOCPA_IDX_CMP2, `TOCPA_IDX_CMP3, `TOCPA_IDX_CMP4,
			`TOCPA_IDX_SHARED: rmask = 32'h0000_ffff;
			`TOCPA_IDX_IEN_TWO, `TOCPA_IDX_FLAGS_TWO: rmask = 32'h0000_0030;
			`TOCPA_IDX_ACC_CTRL: rmask = 32'h0000_0077;
			default: rmask = 32'h0000_0000;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d,
		output logic [31:0] q);
		int t;
		t = 0;
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, i, 2'b00};
		do begin
			@(posedge hclk);
			t++;
		end while (rsp.hreadyout !== 1'b1 && t < 50);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(posedge hclk);
			t++;
		end while (rsp.hreadyout !== 1'b1 && t < 50);
		q = rsp.hrdata;
		chk("hresp", rsp.hresp, 1'b0);
		if (t >= 50) begin
			mismatches++;
		end
	endtask

	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, i, d, q);
		if (i == `TOCPA_IDX_FLAGS_ONE || i == `TOCPA_IDX_FLAGS_TWO) begin
			mdl[i] = mdl[i] & ~d;
		end else begin
			mdl[i] = d & rmask(i);
		end
	endtask

	task automatic tick(input logic [15:0] c);
		tcnt <= c;
		ttick <= 1'b1;
		@(posedge hclk);
		ttick <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge hclk);
		mismatches++;
		final_report;
	end

	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		tcnt = 16'h0;
		ttick = 1'b0;
		mismatches = 0;
		comparisons = 0;
		po = 8'h00;
		for (int i = 0; i < 64; i++) begin
			mdl[i] = (i >= `TOCPA_IDX_CMP1 && i <= `TOCPA_IDX_SHARED) ? 32'h0000_ffff : 32'h0;
		end
		v = $urandom(32'h9b43);
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 1; i < 64; i++) begin
			bus(1'b0, 6'(i), 32'h0, v);
			chk("reset", v, mdl[i]);
		end
		for (int i = 0; i < 5; i++) begin
			wr(6'(`TOCPA_IDX_CMP1 + i), $urandom);
			cv[i] = mdl[`TOCPA_IDX_CMP1 + i][15:0];
			bus(1'b0, 6'(`TOCPA_IDX_CMP1 + i), 32'h0, v);
			chk("cmp", v, mdl[`TOCPA_IDX_CMP1 + i]);
		end
		wr(6'h3f, $urandom);
		bus(1'b0, 6'h3f, 32'h0, v);
		chk("unmapped", v, 32'h0);
		wr(`TOCPA_IDX_PORT_DIR, 32'h0000_00ff);
		wr(`TOCPA_IDX_IEN_ONE, 32'h0000_00f8);
		for (int ch = 2; ch <= 5; ch++) begin
			for (int code = 0; code < 4; code++) begin
				wr(`TOCPA_IDX_PIN_CTRL, code << (2 * (5 - ch)));
				tick(cv[ch - 1]);
				if (code == 1) begin
					po[8 - ch] = ~po[8 - ch];
				end else if (code > 1) begin
					po[8 - ch] = code[0];
				end
				mdl[`TOCPA_IDX_FLAGS_ONE][8 - ch] = 1'b1;
				chk("pin", pins.pa_out, po);
				chk("irq", irq, 1'b1);
				wr(`TOCPA_IDX_FLAGS_ONE, 32'h0);
				bus(1'b0, `TOCPA_IDX_FLAGS_ONE, 32'h0, v);
				chk("flags", v, mdl[`TOCPA_IDX_FLAGS_ONE]);
				wr(`TOCPA_IDX_FLAGS_ONE, 32'h1 << (8 - ch));
				@(posedge hclk);
				chk("irq off", irq, 1'b0);
			end
		end
		// Force a clear action, never a toggle
		wr(`TOCPA_IDX_PIN_CTRL, 32'h0000_0020);
		wr(`TOCPA_IDX_FORCE, 32'h0000_0020);
		chk("force early", pins.pa_out, po);
		tick(16'h0000);
		po[5] = 1'b0;
		chk("force pin", pins.pa_out, po);
		bus(1'b0, `TOCPA_IDX_FLAGS_ONE, 32'h0, v);
		chk("force flag", v, mdl[`TOCPA_IDX_FLAGS_ONE]);
		chk("force irq", irq, 1'b0);
		wr(`TOCPA_IDX_MP_MASK, 32'h0000_00ff);
		bus(1'b0, `TOCPA_IDX_MP_MASK, 32'h0, v);
		chk("mask", v, 32'h0000_00f8);
		wr(`TOCPA_IDX_MP_MASK, $urandom | 32'h0000_0008);
		wr(`TOCPA_IDX_MP_DATA, $urandom);
		tick(cv[0]);
		po = (po & ~mdl[`TOCPA_IDX_MP_MASK][7:0])
			| (mdl[`TOCPA_IDX_MP_DATA][7:0] & mdl[`TOCPA_IDX_MP_MASK][7:0]);
		mdl[`TOCPA_IDX_FLAGS_ONE][7] = 1'b1;
		chk("ch1 pins", pins.pa_out, po);
		bus(1'b0, `TOCPA_IDX_FLAGS_ONE, 32'h0, v);
		chk("ch1 flag", v, mdl[`TOCPA_IDX_FLAGS_ONE]);
		wr(`TOCPA_IDX_FLAGS_ONE, 32'h0000_00f8);
		wr(`TOCPA_IDX_ACC_CTRL, 32'h0000_0004);
		wr(`TOCPA_IDX_PIN_CTRL, 32'h0000_0001);
		wr(`TOCPA_IDX_IEN_ONE, 32'h0000_0008);
		tick(cv[4]);
		chk("ch5 off pin", pins.pa_out, po);
		bus(1'b0, `TOCPA_IDX_FLAGS_ONE, 32'h0, v);
		chk("ch5 off flag", v, mdl[`TOCPA_IDX_FLAGS_ONE]);
		chk("ch5 off irq", irq, 1'b0);
		wr(`TOCPA_IDX_PORT_DIR, 32'h0000_007f);
		wr(`TOCPA_IDX_IEN_TWO, 32'h0000_0030);
		for (int e = 0; e < 2; e++) begin
			wr(`TOCPA_IDX_FLAGS_TWO, 32'h0000_0030);
			wr(`TOCPA_IDX_ACC_COUNT, 32'h0000_00fc);
			wr(`TOCPA_IDX_ACC_CTRL, 32'h0000_0040 | (e << 4));
			lvl = pm.ext7;
			n = 0;
			for (int k = 0; k < 9 + 2 * e; k++) begin
				lvl = ~lvl;
				n += (lvl == e[0]) ? 1 : 0;
			end
			pm.toggle(9 + 2 * e, 1 + 2 * e);
			repeat (8) @(posedge hclk);
			mdl[`TOCPA_IDX_ACC_COUNT] = 32'(8'(252 + n));
			mdl[`TOCPA_IDX_FLAGS_TWO] = 32'h0000_0030;
			bus(1'b0, `TOCPA_IDX_ACC_COUNT, 32'h0, v);
			chk("count", v, mdl[`TOCPA_IDX_ACC_COUNT]);
			bus(1'b0, `TOCPA_IDX_FLAGS_TWO, 32'h0, v);
			chk("flags2", v, mdl[`TOCPA_IDX_FLAGS_TWO]);
			chk("irq2", irq, 1'b1);
		end
		wr(`TOCPA_IDX_ACC_CTRL, 32'h0000_0010);
		pm.toggle(4, 2);
		repeat (8) @(posedge hclk);
		bus(1'b0, `TOCPA_IDX_ACC_COUNT, 32'h0, v);
		chk("count off", v, mdl[`TOCPA_IDX_ACC_COUNT]);
		for (int e = 0; e < 2; e++) begin
			wr(`TOCPA_IDX_ACC_COUNT, 32'h0);
			wr(`TOCPA_IDX_ACC_CTRL, 32'h0000_0060 | (e << 4));
			repeat (224) @(posedge hclk);
			wr(`TOCPA_IDX_ACC_CTRL, 32'h0000_0020);
			mdl[`TOCPA_IDX_ACC_COUNT] = (pm.ext7 != e[0]) ? 32'h3 : 32'h0;
			bus(1'b0, `TOCPA_IDX_ACC_COUNT, 32'h0, v);
			chk("gated", v, mdl[`TOCPA_IDX_ACC_COUNT]);
		end
		wr(`TOCPA_IDX_PORT_DATA, 32'h0);
		wr(`TOCPA_IDX_PORT_DIR, 32'h0000_0080);
		wr(`TOCPA_IDX_ACC_CTRL, 32'h0000_0050);
		wr(`TOCPA_IDX_ACC_COUNT, 32'h0);
		for (int k = 1; k < 4; k++) begin
			wr(`TOCPA_IDX_PORT_DATA, {24'h0, k[0], 7'h00});
		end
		repeat (8) @(posedge hclk);
		bus(1'b0, `TOCPA_IDX_ACC_COUNT, 32'h0, v);
		chk("out feeds count", v, 32'h2);
		chk("dir pins", pins.pa_oe, 8'h80);
		final_report;
	end
endmodule

// ==== testbench/tocpa_port_model.sv ====
/*
 * Far side of port A: external pin levels seen by the block.
 * Assumes pins driven by the block override the external level.
 */
`timescale 1ns/1ps

module tocpa_port_model
	import tocpa_pkg::*;
(
	input  wire logic        hclk,
	input  wire tocpa_pins_t pins,
	output logic [7:0]       pa_in,
	output logic             ext7
);
	logic [6:0] idle;

	initial begin
		ext7 = 1'b0;
		idle = 7'h00;
	end

	// Undriven pins 6 to 0 count up every cycle; undriven bit 7 follows ext7
	always @(posedge hclk) idle <= idle + 7'h01;

	// Driven pins feed back their output level
	assign pa_in = (pins.pa_oe & pins.pa_out) | (~pins.pa_oe & {ext7, idle});

	// Edges on bit 7, one clock apart at the fastest
	task automatic toggle(input int n, input int gap);
		for (int k = 0; k < n; k++) begin
			repeat ((gap < 1) ? 1 : gap) @(posedge hclk);
			ext7 <= ~ext7;
		end
	endtask
endmodule
